// file: logic/i2c_byte_slave.sv
// Byte-wide serial slave: device address, register pointer, data bytes.
// Assumes scl and sda already synchronised to sys_clk.
`timescale 1ns/10ps
`default_nettype none
`include "sensor_link_consts.svh"

module i2c_byte_slave
  import sensor_link_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rdata,
  output logic sda_drive,
  output reg_access_type acc
);

  localparam link_regs_type RESET_STATE = '{st: LS_IDLE, bits: 4'h0,
    shreg: 8'h00, rnw: 1'b0, phase: 2'h0, ptr: 8'h00, sda_drv: 1'b0,
    scl_prev: 1'b1, sda_prev: 1'b1, acc: '0};

  link_regs_type q;
  link_regs_type n;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // ========================================================================
  // Bus engine
  always_comb begin
    n = q;
    n.acc.wr = 1'b0;
    n.acc.rd = 1'b0;
    n.scl_prev = scl;
    n.sda_prev = sda;
    rise = scl & ~q.scl_prev;
    fall = ~scl & q.scl_prev;
    start = scl & q.scl_prev & q.sda_prev & ~sda;
    stop = scl & q.scl_prev & ~q.sda_prev & sda;
    if (!enable || stop) begin
      n.st = LS_IDLE;
      n.sda_drv = 1'b0;
    end else if (start) begin
      n.st = LS_RX;
      n.bits = 4'h0;
      n.phase = 2'h0;
      n.sda_drv = 1'b0;
    end else begin
      unique case (q.st)
        LS_IDLE: begin
        end
        LS_RX: begin
          if (rise) begin
            n.shreg = {q.shreg[6:0], sda};
            n.bits = q.bits + 4'h1;
          end else if (fall && q.bits == 4'h8) begin
            if (q.phase == 2'h0) begin
              // Own address only; direction bit in the lowest place
              if (q.shreg[7:1] == `I2C_DEV_ADDR) begin
                n.rnw = q.shreg[0];
                n.sda_drv = 1'b1;
                n.st = LS_ACK;
              end else begin
                n.st = LS_IDLE;
              end
            end else begin
              n.sda_drv = 1'b1;
              n.st = LS_ACK;
              if (q.phase == 2'h1) begin
                n.ptr = q.shreg;
                // Read view must follow the pointer before the first read
                n.acc.ptr = q.shreg;
              end else begin
                n.acc.wr = 1'b1;
                n.acc.ptr = q.ptr;
                n.acc.wdata = q.shreg;
              end
            end
          end
        end
        LS_ACK: begin
          if (fall) begin
            n.bits = 4'h0;
            n.phase = (q.phase == 2'h2) ? 2'h2 : q.phase + 2'h1;
            if (q.rnw) begin
              // Byte is fetched at the moment its first bit goes out
              n.shreg = rdata;
              n.acc.rd = 1'b1;
              n.acc.ptr = q.ptr;
              n.sda_drv = ~rdata[7];
              n.bits = 4'h1;
              n.st = LS_TX;
            end else begin
              n.sda_drv = 1'b0;
              n.st = LS_RX;
            end
          end
        end
        LS_TX: begin
          if (fall) begin
            if (q.bits == 4'h8) begin
              n.sda_drv = 1'b0;
              n.st = LS_RACK;
            end else begin
              n.shreg = {q.shreg[6:0], 1'b0};
              n.sda_drv = ~q.shreg[6];
              n.bits = q.bits + 4'h1;
            end
          end
        end
        LS_RACK: begin
          if (rise) begin
            n.st = sda ? LS_IDLE : LS_ACK;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  assign sda_drive = q.sda_drv;
  assign acc = q.acc;

endmodule : i2c_byte_slave

`default_nettype wire

// file: logic/pin_sync2.sv
// Two-stage synchroniser for pins from outside the clock domain.
// Assumes a synchronous active-high reset; RESET_VAL is the idle pin level.
`timescale 1ns/10ps
`default_nettype none

module pin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  // ========================================================================
  // State
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_regs_type;

  sync_regs_type q;
  sync_regs_type d;

  // Only the second stage is visible to any logic
  always_comb begin
    d.meta = pin_in;
    d.stable = q.meta;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= {RESET_VAL, RESET_VAL};
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.stable;

endmodule : pin_sync2

`default_nettype wire

// file: logic/sensor_host_link.sv
// Host link of the master sensor: three physical byte registers on the
// serial slave, virtual register engine, integration timer, data-ready
// interrupt and shutter current sink control.
// Assumes sensor data arrive on sys_clk from the conversion logic.
//
// Contract
// - Shutter sink: four currents, switchable on/off
// - Ready after one period; two in modes 2 and 3
// - Ready with interrupts on: line low, flag set
// - Reading channel data releases the interrupt line
// - Later bytes of a value held from first
// - Conversion continues; unread data replaced each cycle
// - Text-command mode: any data read releases line
// - Interrupt operation only in the master sensor
// - Slave active only when select pin chooses it
// - Answers to seven-bit address 49 hex
// - Direction bit one reads, zero writes
// - Flags bit 1 shows inbound byte pending
// - Flags bit 0 shows outbound byte available
// - Inbound byte carries addresses and write data
// - Outbound byte holds data for the master
// - Only three physical registers; rest emulated
// - Address top bit set announces a write
// - Four-byte values are single-precision floats
// - Multi-byte values big-endian, MSB lowest address
`timescale 1ns/10ps
`default_nettype none
`include "sensor_link_consts.svh"

module sensor_host_link
  import sensor_link_pkg::*;
#(
  parameter int IT_STEP_CYCLES = `IT_STEP_US * `SYS_CLK_KHZ / 1000,
  parameter bit IS_MASTER = 1'b1,
  parameter logic [15:0] HW_VERSION = 16'h0001, // Arbitrary value
  parameter logic [15:0] FW_VERSION = 16'h0001 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_port_select_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic text_cmd_mode,
  input wire logic text_cmd_data_read,
  input wire raw_set_type raw_in,
  input wire cal_set_type cal_in,
  input wire logic [7:0] temperature_in,
  output logic int_n,
  output logic shutter_current_sink_en,
  output logic [1:0] shutter_current_sel,
  output logic indicator_en,
  output logic [1:0] indicator_sel,
  output logic [1:0] bank_mode,
  output logic [1:0] gain_sel,
  output logic data_ready_pulse
);

  // ========================================================================
  // Pin synchronisers and bus engine
  logic [2:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic sel_s;
  logic [7:0] phys_rdata;
  logic sda_drive;
  reg_access_type acc;

  pin_sync2 #(
    .WIDTH(3),
    .RESET_VAL(3'h7)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({host_port_select_pin, scl_in, sda_in}),
    .pin_out(pins_sync)
  );

  assign sel_s = pins_sync[2];
  assign scl_s = pins_sync[1];
  assign sda_s = pins_sync[0];

  // Ignores the bus entirely when the pin selects the text port
  i2c_byte_slave u_slave (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(sel_s),
    .scl(scl_s),
    .sda(sda_s),
    .rdata(phys_rdata),
    .sda_drive(sda_drive),
    .acc(acc)
  );

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = sda_drive;

  // ========================================================================
  // Address decoding helpers
  function automatic logic is_raw(input logic [6:0] a);
    return a >= `VREG_RAW_BASE && a <= `VREG_RAW_LAST;
  endfunction : is_raw

  function automatic logic is_cal(input logic [6:0] a);
    return a >= `VREG_CAL_BASE && a <= `VREG_CAL_LAST;
  endfunction : is_cal

  function automatic logic is_sensor(input logic [6:0] a);
    return is_raw(a) || is_cal(a);
  endfunction : is_sensor

  // Big-endian pick of byte k from a 32-bit word
  function automatic logic [7:0] be_byte(input logic [31:0] w,
                                         input logic [1:0] k);
    return w[8'(31 - 8 * k) -: 8];
  endfunction : be_byte

  // ========================================================================
  // State
  localparam core_regs_type RESET_STATE = '{inb: 8'h00, inb_pend: 1'b0,
    outb: 8'h00, outb_avail: 1'b0, vst: VS_ADDR, vaddr: 7'h00,
    int_en: 1'b0, gain: 2'h0, bank: 2'h0, data_rdy: 1'b0,
    int_time: `INT_TIME_RST, sink_sel: `CUR_SEL_RST, sink_en: 1'b0,
    ind_sel: `CUR_SEL_RST, ind_en: 1'b0, int_n: 1'b1, step: 16'h0000,
    units: 8'h00, second_pass: 1'b0, raw: '0, cal: '0, shadow: 32'h0};

  core_regs_type q;
  core_regs_type n;
  logic [6:0] va;
  logic [6:0] roff;
  logic [6:0] coff;
  logic [31:0] word;
  logic [7:0] vbyte;
  logic [7:0] unit_last;
  logic period_end;
  logic ready;
  logic release_int;

  // Physical register read view: flags, inbound reads as zero, outbound
  always_comb begin
    unique case (acc.ptr)
      `PHYS_FLAGS: phys_rdata = {6'h00, q.inb_pend, q.outb_avail};
      `PHYS_OUTBOUND: phys_rdata = q.outb;
      default: phys_rdata = 8'h00;
    endcase
  end

  // ========================================================================
  // Next-state logic
  always_comb begin
    n = q;
    va = q.inb[6:0];
    roff = va - `VREG_RAW_BASE;
    coff = va - `VREG_CAL_BASE;
    word = 32'h0;
    vbyte = 8'h00;
    release_int = 1'b0;

    // Integration timer keeps running whatever the host does
    unit_last = (q.int_time == 8'h00) ? 8'h00 : q.int_time - 8'h01;
    period_end = (q.step == 16'(IT_STEP_CYCLES - 1)) && (q.units == unit_last);
    ready = period_end && (q.bank < `BANK_TWO_PASS || q.second_pass);
    if (q.step == 16'(IT_STEP_CYCLES - 1)) begin
      n.step = 16'h0000;
      n.units = (q.units == unit_last) ? 8'h00 : q.units + 8'h01;
    end else begin
      n.step = q.step + 16'h0001;
    end
    if (period_end) begin
      n.second_pass = (q.bank >= `BANK_TWO_PASS) && !q.second_pass;
    end

    // Host read clear first, so a same-cycle fresh byte wins
    if (acc.rd && acc.ptr == `PHYS_OUTBOUND) begin
      n.outb_avail = 1'b0;
    end

    // Virtual register engine consumes one inbound byte
    if (q.inb_pend) begin
      n.inb_pend = 1'b0;
      if (q.vst == VS_DATA) begin
        n.vst = VS_ADDR;
        unique case (q.vaddr)
          `VREG_CONFIG: begin
            n.int_en = q.inb[`CFG_INT_EN];
            n.gain = q.inb[5:4];
            n.bank = q.inb[3:2];
            if (!q.inb[`CFG_DATA_RDY]) begin
              n.data_rdy = 1'b0;
            end
          end
          `VREG_INT_TIME: n.int_time = q.inb;
          `VREG_LED_CFG: begin
            n.sink_sel = q.inb[5:4];
            n.sink_en = q.inb[3];
            n.ind_sel = q.inb[2:1];
            n.ind_en = q.inb[0];
          end
          default: begin
          end
        endcase
      end else if (q.inb[`VREG_WR_MARK]) begin
        n.vaddr = va;
        n.vst = VS_DATA;
      end else begin
        // First byte of a value captures the whole value in the shadow
        if (is_raw(va)) begin
          word = {16'h0000, q.raw[roff[3:1]]};
          if (!roff[0]) begin
            n.shadow = word;
            vbyte = be_byte(word, 2'h2);
          end else begin
            vbyte = be_byte(q.shadow, 2'h3);
          end
        end else if (is_cal(va)) begin
          word = q.cal[coff[4:2]];
          if (coff[1:0] == 2'h0) begin
            n.shadow = word;
            vbyte = be_byte(word, 2'h0);
          end else begin
            vbyte = be_byte(q.shadow, coff[1:0]);
          end
        end else begin
          unique case (va)
            `VREG_HW_VER_H: vbyte = HW_VERSION[15:8];
            `VREG_HW_VER_L: vbyte = HW_VERSION[7:0];
            `VREG_FW_VER_H: vbyte = FW_VERSION[15:8];
            `VREG_FW_VER_L: vbyte = FW_VERSION[7:0];
            `VREG_CONFIG: vbyte = {1'b0, q.int_en, q.gain, q.bank,
                                   q.data_rdy, 1'b0};
            `VREG_INT_TIME: vbyte = q.int_time;
            `VREG_TEMP: vbyte = temperature_in;
            `VREG_LED_CFG: vbyte = {2'h0, q.sink_sel, q.sink_en,
                                    q.ind_sel, q.ind_en};
            default: vbyte = 8'h00;
          endcase
        end
        n.outb = vbyte;
        n.outb_avail = 1'b1;
        if (is_sensor(va)) begin
          release_int = 1'b1;
          n.data_rdy = 1'b0;
        end
      end
    end

    // Host side of the physical registers
    // A byte written while pending is dropped, the master was told to wait
    if (acc.wr && acc.ptr == `PHYS_INBOUND && !q.inb_pend) begin
      n.inb = acc.wdata;
      n.inb_pend = 1'b1;
    end

    // Interrupt line: release first so a same-cycle ready wins
    if (text_cmd_mode && text_cmd_data_read) begin
      release_int = 1'b1;
    end
    if (release_int || !q.int_en) begin
      n.int_n = 1'b1;
    end
    if (ready) begin
      n.raw = raw_in;
      n.cal = cal_in;
      n.data_rdy = 1'b1;
      if (q.int_en && IS_MASTER) begin
        n.int_n = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= RESET_STATE;
    end else begin
      q <= n;
    end
  end

  // ========================================================================
  // Outputs
  assign int_n = q.int_n;
  assign shutter_current_sink_en = q.sink_en;
  assign shutter_current_sel = q.sink_sel;
  assign indicator_en = q.ind_en;
  assign indicator_sel = q.ind_sel;
  assign bank_mode = q.bank;
  assign gain_sel = q.gain;
  assign data_ready_pulse = ready;

endmodule : sensor_host_link

`default_nettype wire

// file: logic/sensor_link_consts.svh
// Constants of the sensor host-link block: offsets, fields, resets, timing.
// Assumes inclusion from the package and from the design modules.
`ifndef SENSOR_LINK_CONSTS_SVH
`define SENSOR_LINK_CONSTS_SVH

// ==========================================================================
// Bus address and physical byte registers
`define I2C_DEV_ADDR 7'h49
`define PHYS_FLAGS 8'h00
`define PHYS_INBOUND 8'h01
`define PHYS_OUTBOUND 8'h02
`define FLAG_INB_PEND 1
`define FLAG_OUTB_AVAIL 0

// ==========================================================================
// Virtual register map
`define VREG_WR_MARK 7
`define VREG_HW_VER_H 7'h00
`define VREG_HW_VER_L 7'h01
`define VREG_FW_VER_H 7'h02
`define VREG_FW_VER_L 7'h03
`define VREG_CONFIG 7'h04
`define VREG_INT_TIME 7'h05
`define VREG_TEMP 7'h06
`define VREG_LED_CFG 7'h07
`define VREG_RAW_BASE 7'h08
`define VREG_RAW_LAST 7'h13
`define VREG_CAL_BASE 7'h14
`define VREG_CAL_LAST 7'h2B

// ==========================================================================
// Field positions and reset values
`define CFG_INT_EN 6
`define CFG_DATA_RDY 1
`define BANK_TWO_PASS 2'h2
`define INT_TIME_RST 8'h20
`define CUR_SEL_RST 2'h0

// ==========================================================================
// Timing: one integration-time step, and the clock rate
`define IT_STEP_US 2800
`define SYS_CLK_KHZ 10000

`endif

// file: logic/sensor_link_pkg.sv
// Types shared by the sensor host-link modules.
// Assumes the constants header sits beside it.
`include "sensor_link_consts.svh"

package sensor_link_pkg;

  // ========================================================================
  // Sensor data carriers
  typedef struct packed {
    logic sign;
    logic [7:0] expo;
    logic [22:0] frac;
  } float32_type;

  typedef logic [5:0][15:0] raw_set_type;
  typedef float32_type [5:0] cal_set_type;

  // ========================================================================
  // Physical register access from the bus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ptr;
    logic [7:0] wdata;
  } reg_access_type;

  typedef enum logic [4:0] {
    LS_IDLE = 5'b00001,
    LS_RX = 5'b00010,
    LS_ACK = 5'b00100,
    LS_TX = 5'b01000,
    LS_RACK = 5'b10000
  } link_state_type;

  typedef struct packed {
    link_state_type st;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic rnw;
    logic [1:0] phase;
    logic [7:0] ptr;
    logic sda_drv;
    logic scl_prev;
    logic sda_prev;
    reg_access_type acc;
  } link_regs_type;

  typedef enum logic [1:0] {
    VS_ADDR = 2'b01,
    VS_DATA = 2'b10
  } vstate_type;

  typedef struct packed {
    logic [7:0] inb;
    logic inb_pend;
    logic [7:0] outb;
    logic outb_avail;
    vstate_type vst;
    logic [6:0] vaddr;
    logic int_en;
    logic [1:0] gain;
    logic [1:0] bank;
    logic data_rdy;
    logic [7:0] int_time;
    logic [1:0] sink_sel;
    logic sink_en;
    logic [1:0] ind_sel;
    logic ind_en;
    logic int_n;
    logic [15:0] step;
    logic [7:0] units;
    logic second_pass;
    raw_set_type raw;
    cal_set_type cal;
    logic [31:0] shadow;
  } core_regs_type;

endpackage : sensor_link_pkg

// file: testbench/i2c_host_model.sv
// Serial bus master model for the sensor host link pins.
// Assumes the bench resolves sda from both pull-downs and a pull-up.
`timescale 1ns/10ps
`default_nettype none

module i2c_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // ====================
  // 800 ns bits; scl stands high outside frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic bit_io(input logic tx, output logic rx);
    sda_pull = ~tx;
    #200 scl = 1'b1;
    #200 rx = sda_line;
    #200 scl = 1'b0;
    #200;
  endtask : bit_io

  task automatic start_bit();
    @(negedge sys_clk);
    sda_pull = 1'b0;
    #200 scl = 1'b1;
    #200 sda_pull = 1'b1;
    #200 scl = 1'b0;
    #200;
  endtask : start_bit

  // Stop then fresh start, not a repeated start: safer while ACK lingers
  task automatic stop_bit();
    sda_pull = 1'b1;
    #200 scl = 1'b1;
    #200 sda_pull = 1'b0;
    #400;
  endtask : stop_bit

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                         output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, ack);
  endtask : byte_io

  task automatic reg_write(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic nak);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_bit();
    byte_io({dev, 1'b0}, rx, a0);
    byte_io(ptr, rx, a1);
    byte_io(d, rx, a2);
    stop_bit();
    nak = a0 | a1 | a2;
  endtask : reg_write

  task automatic reg_read(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] d, output logic nak);
    logic [7:0] rx;
    logic a0, a1, a2, x;
    start_bit();
    byte_io({dev, 1'b0}, rx, a0);
    byte_io(ptr, rx, a1);
    stop_bit();
    start_bit();
    byte_io({dev, 1'b1}, rx, a2);
    byte_io(8'hFF, d, x);
    stop_bit();
    nak = a0 | a1 | a2;
  endtask : reg_read
endmodule : i2c_host_model
`default_nettype wire

// file: testbench/sensor_host_link_asserts.sv
// Checker for the sensor host link, on its top-level ports only.
// Assumes the bench binds it into sensor_host_link.
`timescale 1ns/10ps
`default_nettype none

module sensor_host_link_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_port_select_pin,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic text_cmd_mode,
  input wire logic text_cmd_data_read,
  input wire logic int_n,
  input wire logic shutter_current_sink_en,
  input wire logic [1:0] shutter_current_sel,
  input wire logic data_ready_pulse
);
  // ====================
  // Idle means both pins high for 8 cycles, past the synchronisers
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_reset_quiet: assert property (disable iff (1'b0) rst |=>
    int_n && !sda_oe && !shutter_current_sink_en &&
    shutter_current_sel == 2'h0) else $error("outputs not reset");
  a_int_fall_cause: assert property ($fell(int_n) |->
    $past(data_ready_pulse)) else $error("int_n fell without ready");
  a_ready_gap: assert property (data_ready_pulse |=>
    !data_ready_pulse [*8]) else $error("ready pulses too close");
  a_int_hold_low: assert property ((scl_in && sda_in) [*8] ##0
    (!int_n && !text_cmd_data_read) |=> !int_n)
    else $error("int_n released with no read");
  a_text_release: assert property (text_cmd_mode &&
    text_cmd_data_read && !data_ready_pulse |=> int_n)
    else $error("text read left int_n low");
  a_sda_clk_high: assert property (scl_in [*3] |->
    $stable(sda_oe)) else $error("sda drive moved with scl high");
  a_oe_needs_select: assert property ($rose(sda_oe) |->
    $past(host_port_select_pin, 3)) else $error("sda driven unselected");
  a_unselected_quiet: assert property (
    !host_port_select_pin [*4] |-> !sda_oe)
    else $error("sda driven while pin deselects");
  a_sink_idle: assert property ((scl_in && sda_in) [*8] |=>
    $stable({shutter_current_sel, shutter_current_sink_en}))
    else $error("sink changed with bus idle");
  a_sda_open_drain: assert property (sda_out == 1'b0)
    else $error("sda output value not low");
endmodule : sensor_host_link_asserts
`default_nettype wire

// file: testbench/sensor_host_link_tb.sv
// Bench for the sensor host link: virtual access, shutter, interrupt.
// Assumes the host model drives the serial pins.
`timescale 1ns/10ps
`default_nettype none
`include "sensor_link_consts.svh"

module sensor_host_link_tb;
  import sensor_link_pkg::*;
  localparam logic [6:0] dev_addr = `I2C_DEV_ADDR;
  logic sys_clk, rst, sel_pin, text_mode, text_rd, scl, sda_pull;
  logic sda_line, sda_oe, int_n, sink_en, ind_en, drp, nk;
  logic [1:0] sink_sel, ind_sel, bank, gain;
  logic [7:0] temp_v, b, d;
  raw_set_type raw_v;
  cal_set_type cal_v;
  int n, miscompares, num_checks;

  // ====================
  // Pull-up wins unless a party pulls low
  assign sda_line = ~(sda_pull | sda_oe);

  sensor_host_link #(.IT_STEP_CYCLES(20)) DUT (.sys_clk(sys_clk),
    .rst(rst), .host_port_select_pin(sel_pin), .scl_in(scl),
    .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .text_cmd_mode(text_mode), .text_cmd_data_read(text_rd),
    .raw_in(raw_v), .cal_in(cal_v), .temperature_in(temp_v),
    .int_n(int_n), .shutter_current_sink_en(sink_en),
    .shutter_current_sel(sink_sel), .indicator_en(ind_en),
    .indicator_sel(ind_sel), .bank_mode(bank), .gain_sel(gain),
    .data_ready_pulse(drp));
  i2c_host_model host (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl(scl), .sda_pull(sda_pull));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Bounded waits; a spent bound ends the run as a failure
  task automatic wait_pulse(output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (drp !== 1'b1 && c < 6000);
    if (c >= 6000) begin
      miscompares++;
      stop_test();
    end
  endtask : wait_pulse

  task automatic poll(input int bit_i, input logic want);
    logic [7:0] f;
    logic k;
    int i;
    i = 0;
    do begin
      host.reg_read(dev_addr, `PHYS_FLAGS, f, k);
      i++;
    end while (f[bit_i] !== want && i < 20);
    if (i >= 20) begin
      miscompares++;
      stop_test();
    end
  endtask : poll

  task automatic vwrite(input logic [6:0] va, input logic [7:0] v);
    poll(`FLAG_INB_PEND, 1'b0);
    host.reg_write(dev_addr, `PHYS_INBOUND, {1'b1, va}, nk);
    poll(`FLAG_INB_PEND, 1'b0);
    host.reg_write(dev_addr, `PHYS_INBOUND, v, nk);
  endtask : vwrite

  task automatic vread(input logic [6:0] va, output logic [7:0] v);
    logic [7:0] f;
    poll(`FLAG_INB_PEND, 1'b0);
    host.reg_write(dev_addr, `PHYS_INBOUND, {1'b0, va}, nk);
    poll(`FLAG_OUTB_AVAIL, 1'b1);
    host.reg_read(dev_addr, `PHYS_OUTBOUND, v, nk);
    host.reg_read(dev_addr, `PHYS_FLAGS, f, nk);
    chk("flags after read", f, 16'h0000);
  endtask : vread

  initial begin
    rst = 1'b1;
    sel_pin = 1'b1;
    text_mode = 1'b0;
    text_rd = 1'b0;
    raw_v = '0;
    raw_v[0] = 16'hA1B2;
    cal_v = '0;
    cal_v[0] = 32'h3E200000;
    temp_v = 8'h5A;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("int_n", int_n, 16'h0001);
    host.reg_read(dev_addr, `PHYS_FLAGS, b, nk);
    chk("flags", {nk, b}, 16'h0000);
    host.reg_read(7'h4A, `PHYS_FLAGS, b, nk);
    chk("other addr nak", nk, 16'h0001);
    sel_pin = 1'b0;
    repeat (4) @(negedge sys_clk);
    host.reg_read(dev_addr, `PHYS_FLAGS, b, nk);
    chk("unselected nak", nk, 16'h0001);
    sel_pin = 1'b1;
    $display("test addressing done");
    for (int k = 0; k < 4; k++) begin
      d = {2'h0, k[1:0], 1'b1, k[1:0], 1'b1};
      vwrite(`VREG_LED_CFG, d);
      chk("sink", {sink_en, sink_sel}, {1'b1, k[1:0]});
      chk("indicator", {ind_en, ind_sel}, {1'b1, k[1:0]});
      vread(`VREG_LED_CFG, b);
      chk("led cfg", b, d);
    end
    vwrite(`VREG_LED_CFG, 8'h00);
    chk("sink off", sink_en, 16'h0000);
    vread(`VREG_TEMP, b);
    chk("temperature", b, 16'h005A);
    $display("test shutter done");
    vwrite(`VREG_INT_TIME, 8'h01);
    vwrite(`VREG_CONFIG, 8'h40);
    wait_pulse(n);
    wait_pulse(n);
    chk("period one bank", n[15:0], 16'h0014);
    vwrite(`VREG_CONFIG, 8'h58);
    chk("gain bank", {gain, bank}, 16'h0006);
    wait_pulse(n);
    wait_pulse(n);
    chk("period two banks", n[15:0], 16'h0028);
    @(negedge sys_clk);
    chk("int held low", int_n, 16'h0000);
    $display("test interrupt done");
    vwrite(`VREG_CONFIG, 8'h40);
    vwrite(`VREG_INT_TIME, 8'hFF);
    wait_pulse(n);
    vread(`VREG_RAW_BASE, b);
    chk("raw high", b, 16'h00A1);
    chk("int released", int_n, 16'h0001);
    raw_v[0] = 16'hC3D4;
    wait_pulse(n);
    @(negedge sys_clk);
    chk("int low again", int_n, 16'h0000);
    vread(`VREG_RAW_BASE + 7'h01, b);
    chk("raw low shadow", b, 16'h00B2);
    vread(`VREG_RAW_BASE, b);
    chk("raw next cycle", b, 16'h00C3);
    vread(`VREG_CAL_BASE, b);
    chk("cal top byte", b, 16'h003E);
    vread(`VREG_CAL_BASE + 7'h01, b);
    chk("cal second byte", b, 16'h0020);
    $display("test shadow done");
    text_mode = 1'b1;
    wait_pulse(n);
    @(negedge sys_clk);
    chk("text int low", int_n, 16'h0000);
    text_rd = 1'b1;
    @(negedge sys_clk);
    text_rd = 1'b0;
    @(negedge sys_clk);
    chk("text int high", int_n, 16'h0001);
    $display("test text mode done");
    stop_test();
  end
endmodule : sensor_host_link_tb

bind sensor_host_link sensor_host_link_asserts chk_u (.sys_clk, .rst,
  .host_port_select_pin, .scl_in, .sda_in, .sda_out, .sda_oe,
  .text_cmd_mode, .text_cmd_data_read, .int_n, .shutter_current_sink_en,
  .shutter_current_sel, .data_ready_pulse);
`default_nettype wire
